// *** hdl/pc_card_dma_cfg.svh ***
// constants for the pc card 16 dma support block
`ifndef PC_CARD_DMA_CFG_SVH
`define PC_CARD_DMA_CFG_SVH
// distributed register offsets (low nibble of the i/o address)
`define OFS_ADDRESS_PAGE 4'h0
`define OFS_TRANSFER_COUNT 4'h4
`define OFS_STATUS_COMMAND 4'h8
`define OFS_MASK_CLEAR 4'hc
// command, mode, status and mask fields
`define CMD_DISABLE_BIT 2
`define MODE_DIR_LSB 2
`define MODE_DEC_BIT 5
`define STAT_TC_BIT 0
`define STAT_REQ_BIT 4
`define MASK_BIT 0
// system control fields
`define SYS_GLOBAL_CENTRAL_DMA_ENABLE_BIT 3
`define SYS_SOCKET_CENTRAL_DMA_ENABLE_BIT 19
`define SYS_CHAN_LSB 16
`define SYS_CTRL_RESET 32'h0000_0000
`define SYS_CTRL_WMASK 32'h0008_0008
// channel code that is not used
`define CHAN_UNUSED 3'h4
// centralized dma i/o addresses
`define CIO_NORMAL 8'h00
`define CIO_NORMAL_TC 8'h04
`define CIO_VERIFY 8'hc0
`define CIO_VERIFY_TC 8'hc4
// reset values
`define CMD_RESET 8'h00
`define MODE_RESET 8'h00
`define MASK_RESET 1'b1
// serial request frame: start, three channel bits, request level
`define SER_REQ_BITS 3'd5
`define SER_GNT_BITS 3'd4
`endif

// *** hdl/pc_card_dma_pkg.sv ***
// types shared by the pc card 16 dma support files
package pc_card_dma_pkg;
  typedef enum {
    D_IDLE,
    D_COLLECT,
    D_BUSREQ,
    D_XFER,
    D_CARD
  } distributed_dma_state_t;
  typedef enum logic [1:0] {
    SEL_AUDIO,
    SEL_IO16,
    SEL_CARD_INPUT_ACK_PIN,
    SEL_NONE
  } card_dma_request_sel_t;
  typedef enum logic [1:0] {
    DIR_VERIFY,
    DIR_CARD_TO_MEM,
    DIR_MEM_TO_CARD,
    DIR_ILLEGAL
  } xfer_dir_t;
endpackage

// *** hdl/central_dma_link.sv ***
// serialized channel request and grant for centralized dma
`timescale 1ns/1ns
`include "pc_card_dma_cfg.svh"
module central_dma_link (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // request side
  input wire logic enable_i,
  input wire logic [2:0] channel_i,
  input wire logic want_i,
  output logic granted_o,
  // serial lines
  output logic serial_channel_request_o,
  input wire logic serial_channel_grant_i
);
  logic sent_want_r;
  logic [4:0] req_shift_r;
  logic [2:0] req_cnt_r;
  logic [2:0] gnt_cnt_r;
  logic [2:0] gnt_shift_r;
  logic want_q;

  assign want_q = want_i & enable_i;

  // frame out whenever the wanted level changes, line idles high
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sent_want_r <= 1'b0;
      req_shift_r <= 5'h1f;
      req_cnt_r <= 3'd0;
      serial_channel_request_o <= 1'b1;
    end else if (ce_i) begin
      if (req_cnt_r != 3'd0) begin
        serial_channel_request_o <= req_shift_r[0];
        req_shift_r <= {1'b1, req_shift_r[4:1]};
        req_cnt_r <= req_cnt_r - 3'd1;
      end else if (want_q != sent_want_r) begin
        sent_want_r <= want_q;
        req_shift_r <= {want_q, channel_i, 1'b0};
        req_cnt_r <= `SER_REQ_BITS;
        serial_channel_request_o <= 1'b1;
      end else begin
        serial_channel_request_o <= 1'b1;
      end
    end
  end

  // grant frame: low start bit then channel lsb first
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      gnt_cnt_r <= 3'd0;
      gnt_shift_r <= 3'h0;
      granted_o <= 1'b0;
    end else if (ce_i) begin
      if (gnt_cnt_r == 3'd0) begin
        if (!serial_channel_grant_i) begin
          gnt_cnt_r <= `SER_GNT_BITS - 3'd1;
        end
        if (!sent_want_r) begin
          granted_o <= 1'b0;
        end
      end else begin
        gnt_shift_r <= {serial_channel_grant_i, gnt_shift_r[2:1]};
        gnt_cnt_r <= gnt_cnt_r - 3'd1;
        if (gnt_cnt_r == 3'd1) begin
          granted_o <= sent_want_r &&
            ({serial_channel_grant_i, gnt_shift_r[2:1]} == channel_i);
        end
      end
    end
  end
endmodule

// *** hdl/pc_card_dma.sv ***
// pc card 16 distributed and centralized dma support engine
`timescale 1ns/1ns
`include "pc_card_dma_cfg.svh"
//
// Contract
// - reserved registers read zero and ignore writes.
// - obsolete legacy bits are read-only and do nothing.
// - reads and writes at one offset reach different registers.
// - card request comes from audio, io16 or input-ack pin; enable too.
// - register base address and byte or word size come from config.
// - card to memory: collect element, request bus, single write.
// - memory to card: request bus, single read, pass data to card.
// - repeat per element with fresh arbitration until count expires.
// - register accesses keep working during a transfer.
// - channel reset mid-transfer gives terminal count, ends cycle, sets status.
// - demand mode; acknowledge held while the card keeps requesting.
// - terminal count on output enable for writes, write enable for reads.
// - acknowledge always on the attribute memory select pin.
// - centralized request and grant use serialized channel frames.
// - per-socket centralized enable resets to zero.
// - channel codes 0-3 byte, 4 unused, 5-7 word.
// - centralized width follows channel; distributed registers unused.
// - decode 00h, 04h, c0h, c4h cycles; verify is read only.
// - centralized mode is target only, no master sequencing.
module pc_card_dma (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // pci i/o target
  input wire logic io_req_i,
  input wire logic io_wr_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [3:0] io_be_i,
  input wire logic [31:0] io_wdata_i,
  output logic io_ack_o,
  output logic [31:0] io_rdata_o,
  // socket dma configuration
  input wire logic distributed_dma_enable_i,
  input wire pc_card_dma_pkg::card_dma_request_sel_t card_dma_request_select_i,
  input wire logic [11:0] distributed_dma_base_i,
  input wire logic distributed_dma_word_i,
  // system control register
  input wire logic sysctl_wr_i,
  input wire logic [31:0] sysctl_wdata_i,
  output logic [31:0] sysctl_o,
  // pci master
  output logic mst_req_o,
  input wire logic mst_gnt_i,
  input wire logic bus_idle_i,
  output logic mst_start_o,
  output logic mst_write_o,
  output logic mst_word_o,
  output logic [31:0] mst_addr_o,
  output logic [31:0] mst_wdata_o,
  input wire logic mst_done_i,
  input wire logic [31:0] mst_rdata_i,
  // card side
  input wire logic card_audio_pin_n_i,
  input wire logic card_io16_pin_n_i,
  input wire logic card_input_ack_pin_n_i,
  input wire logic [15:0] card_rdata_i,
  input wire logic card_rvalid_i,
  output logic [15:0] card_wdata_o,
  output logic card_wr_stb_o,
  input wire logic card_wr_done_i,
  output logic card_oe_n_o,
  output logic card_we_n_o,
  output logic card_reg_n_o,
  // centralized dma link
  output logic serial_channel_request_o,
  input wire logic serial_channel_grant_i,
  output logic distributed_dma_busy_o
);
  import pc_card_dma_pkg::*;

  distributed_dma_state_t state_r, state_nxt;
  logic [23:0] base_addr_r, cur_addr_r;
  logic [15:0] base_cnt_r, cur_cnt_r;
  logic [7:0] cmd_r, mode_r;
  logic mask_r, tc_r, granted;
  logic [31:0] sysctl_r;
  logic [15:0] data_r;
  logic card_req, reg_hit, wr_hit, rd_hit, mclr, stat_rd, go;
  logic elem_done, last_elem, tc_pulse;
  logic cen_on, cen_active, cen_hit, cen_rd, cen_tc;
  logic [2:0] chan;
  xfer_dir_t dir;

  // next address, stepping by element size and direction
  function automatic logic [23:0] step_addr(input logic [23:0] a,
                                             input logic word,
                                             input logic dec);
    logic [23:0] s;
    s = word ? 24'h00_0002 : 24'h00_0001;
    step_addr = dec ? a - s : a + s;
  endfunction

  // card request from the selected pin, active low
  always_comb begin
    case (card_dma_request_select_i)
      SEL_AUDIO: card_req = !card_audio_pin_n_i;
      SEL_IO16: card_req = !card_io16_pin_n_i;
      SEL_CARD_INPUT_ACK_PIN: card_req = !card_input_ack_pin_n_i;
      default: card_req = 1'b0;
    endcase
  end

  assign dir = xfer_dir_t'(mode_r[`MODE_DIR_LSB +: 2]);
  assign reg_hit = io_req_i &&
    (io_addr_i[15:4] == distributed_dma_base_i);
  assign wr_hit = reg_hit && io_wr_i;
  assign rd_hit = reg_hit && !io_wr_i;
  assign mclr = wr_hit && (io_addr_i[3:0] == `OFS_MASK_CLEAR) && io_be_i[1];
  assign stat_rd = rd_hit && (io_addr_i[3:0] == `OFS_STATUS_COMMAND);
  assign go = distributed_dma_enable_i && !mask_r &&
    !cmd_r[`CMD_DISABLE_BIT] && card_req &&
    (dir == DIR_CARD_TO_MEM || dir == DIR_MEM_TO_CARD);
  assign last_elem = (cur_cnt_r == 16'h0000);
  assign tc_pulse = (elem_done && last_elem) ||
    (mclr && state_r != D_IDLE);

  // centralized mode decode
  assign chan = sysctl_r[`SYS_CHAN_LSB +: 3];
  assign cen_on = sysctl_r[`SYS_GLOBAL_CENTRAL_DMA_ENABLE_BIT] &&
    sysctl_r[`SYS_SOCKET_CENTRAL_DMA_ENABLE_BIT] && (chan != `CHAN_UNUSED);
  assign cen_active = cen_on && granted && card_req;
  assign cen_hit = io_req_i && cen_active && (io_addr_i[15:8] == 8'h00) &&
    (io_addr_i[7:0] == `CIO_NORMAL || io_addr_i[7:0] == `CIO_NORMAL_TC ||
     io_addr_i[7:0] == `CIO_VERIFY || io_addr_i[7:0] == `CIO_VERIFY_TC);
  assign cen_rd = cen_hit && !io_wr_i;
  assign cen_tc = cen_hit && io_addr_i[2] &&
    (!io_wr_i || !io_addr_i[7]);

  central_dma_link u_link (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .enable_i(cen_on),
    .channel_i(chan),
    .want_i(card_req),
    .granted_o(granted),
    .serial_channel_request_o(serial_channel_request_o),
    .serial_channel_grant_i(serial_channel_grant_i)
  );

  // distributed engine sequencing
  always_comb begin
    state_nxt = state_r;
    elem_done = 1'b0;
    case (state_r)
      D_IDLE: begin
        if (go) begin
          state_nxt = (dir == DIR_CARD_TO_MEM) ? D_COLLECT : D_BUSREQ;
        end
      end
      D_COLLECT: begin
        if (!card_req) begin
          state_nxt = D_IDLE;
        end else if (card_rvalid_i) begin
          state_nxt = D_BUSREQ;
        end
      end
      D_BUSREQ: begin
        if (mst_gnt_i && bus_idle_i) begin
          state_nxt = D_XFER;
        end
      end
      D_XFER: begin
        if (mst_done_i) begin
          if (dir == DIR_MEM_TO_CARD) begin
            state_nxt = D_CARD;
          end else begin
            elem_done = 1'b1;
          end
        end
      end
      D_CARD: begin
        if (card_wr_done_i) begin
          elem_done = 1'b1;
        end
      end
      default: state_nxt = D_IDLE;
    endcase
    if (elem_done) begin
      if (last_elem || !go) begin
        state_nxt = D_IDLE;
      end else begin
        state_nxt = (dir == DIR_CARD_TO_MEM) ? D_COLLECT : D_BUSREQ;
      end
    end
    if (mclr) begin
      state_nxt = D_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= D_IDLE;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  // address and count registers, written by software or stepped
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      base_addr_r <= 24'h00_0000;
      cur_addr_r <= 24'h00_0000;
      base_cnt_r <= 16'h0000;
      cur_cnt_r <= 16'h0000;
    end else if (ce_i) begin
      if (wr_hit && io_addr_i[3:0] == `OFS_ADDRESS_PAGE) begin
        for (int b = 0; b < 3; b++) begin
          if (io_be_i[b]) begin
            base_addr_r[b*8 +: 8] <= io_wdata_i[b*8 +: 8];
            cur_addr_r[b*8 +: 8] <= io_wdata_i[b*8 +: 8];
          end
        end
      end else if (elem_done) begin
        cur_addr_r <= step_addr(cur_addr_r, distributed_dma_word_i,
                                mode_r[`MODE_DEC_BIT]);
      end
      if (wr_hit && io_addr_i[3:0] == `OFS_TRANSFER_COUNT) begin
        for (int b = 0; b < 2; b++) begin
          if (io_be_i[b]) begin
            base_cnt_r[b*8 +: 8] <= io_wdata_i[b*8 +: 8];
            cur_cnt_r[b*8 +: 8] <= io_wdata_i[b*8 +: 8];
          end
        end
      end else if (elem_done && !last_elem) begin
        cur_cnt_r <= cur_cnt_r - 16'h0001;
      end
    end
  end

  // command, mode and mask; request byte has no function
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cmd_r <= `CMD_RESET;
      mode_r <= `MODE_RESET;
      mask_r <= `MASK_RESET;
    end else if (ce_i) begin
      if (mclr) begin
        cmd_r <= `CMD_RESET;
        mask_r <= `MASK_RESET;
      end else if (wr_hit && io_addr_i[3:0] == `OFS_STATUS_COMMAND) begin
        if (io_be_i[0]) begin
          cmd_r <= io_wdata_i[7:0];
        end
        if (io_be_i[3]) begin
          mode_r <= io_wdata_i[31:24];
        end
      end else if (wr_hit && io_addr_i[3:0] == `OFS_MASK_CLEAR &&
                   io_be_i[3]) begin
        mask_r <= io_wdata_i[24 + `MASK_BIT];
      end
      if (tc_pulse) begin
        mask_r <= 1'b1;
      end
    end
  end

  // terminal count status; a new count wins over a read clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tc_r <= 1'b0;
    end else if (ce_i) begin
      if (tc_pulse) begin
        tc_r <= 1'b1;
      end else if (stat_rd) begin
        tc_r <= 1'b0;
      end
    end
  end

  // system control: only the two enables and the channel field are writable here
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sysctl_r <= `SYS_CTRL_RESET;
    end else if (ce_i) begin
      if (sysctl_wr_i) begin
        sysctl_r <= (sysctl_wdata_i & `SYS_CTRL_WMASK) |
          {13'h0000, sysctl_wdata_i[18:16], 16'h0000};
      end
    end
  end

  // i/o target answer, one cycle after every request
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      io_ack_o <= 1'b0;
      io_rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      io_ack_o <= io_req_i;
      io_rdata_o <= 32'h0000_0000;
      if (cen_rd) begin
        io_rdata_o <= chan[2] ? {16'h0000, card_rdata_i} :
          {24'h00_0000, card_rdata_i[7:0]};
      end else if (rd_hit) begin
        if (io_addr_i[3:0] == `OFS_ADDRESS_PAGE) begin
          io_rdata_o <= {8'h00, cur_addr_r};
        end else if (io_addr_i[3:0] == `OFS_TRANSFER_COUNT) begin
          io_rdata_o <= {16'h0000, cur_cnt_r};
        end else if (io_addr_i[3:0] == `OFS_STATUS_COMMAND) begin
          io_rdata_o <= {24'h00_0000, 3'h0, card_req, 3'h0, tc_r};
        end
      end
    end
  end

  // pci master strobes and data
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mst_req_o <= 1'b0;
      mst_start_o <= 1'b0;
      mst_write_o <= 1'b0;
      mst_word_o <= 1'b0;
      mst_addr_o <= 32'h0000_0000;
      mst_wdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      mst_req_o <= (state_nxt == D_BUSREQ);
      mst_start_o <= (state_r == D_BUSREQ) && (state_nxt == D_XFER);
      mst_write_o <= (dir == DIR_CARD_TO_MEM);
      mst_word_o <= distributed_dma_word_i;
      mst_addr_o <= {8'h00, cur_addr_r};
      mst_wdata_o <= {16'h0000, data_r};
    end
  end

  // element data holding register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      data_r <= 16'h0000;
    end else if (ce_i) begin
      if (state_r == D_COLLECT && card_rvalid_i) begin
        data_r <= distributed_dma_word_i ? card_rdata_i :
          {8'h00, card_rdata_i[7:0]};
      end else if (state_r == D_XFER && mst_done_i) begin
        data_r <= distributed_dma_word_i ? mst_rdata_i[15:0] :
          {8'h00, mst_rdata_i[7:0]};
      end
    end
  end

  // card pins: ack on attribute select, tc on oe or we
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      card_wdata_o <= 16'h0000;
      card_wr_stb_o <= 1'b0;
      card_oe_n_o <= 1'b1;
      card_we_n_o <= 1'b1;
      card_reg_n_o <= 1'b1;
      distributed_dma_busy_o <= 1'b0;
    end else if (ce_i) begin
      card_wr_stb_o <= 1'b0;
      if (state_r == D_XFER && mst_done_i && dir == DIR_MEM_TO_CARD) begin
        card_wdata_o <= distributed_dma_word_i ? mst_rdata_i[15:0] :
          {8'h00, mst_rdata_i[7:0]};
        card_wr_stb_o <= 1'b1;
      end else if (cen_hit && io_wr_i && !io_addr_i[7]) begin
        card_wdata_o <= chan[2] ? io_wdata_i[15:0] :
          {8'h00, io_wdata_i[7:0]};
        card_wr_stb_o <= 1'b1;
      end
      card_oe_n_o <= !((tc_pulse && dir == DIR_CARD_TO_MEM) ||
        (cen_tc && !io_wr_i));
      card_we_n_o <= !((tc_pulse && dir == DIR_MEM_TO_CARD) ||
        (cen_tc && io_wr_i));
      card_reg_n_o <= !(((state_nxt != D_IDLE) && card_req) ||
        cen_active);
      distributed_dma_busy_o <= (state_nxt != D_IDLE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sysctl_o <= `SYS_CTRL_RESET;
    end else if (ce_i) begin
      sysctl_o <= sysctl_r;
    end
  end
endmodule

// *** verification/pc_card_dma_monitor.sv ***
// assertion checker for the pc card 16 dma engine ports
`timescale 1ns/1ns
module pc_card_dma_monitor (
  // observed ports
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic io_req_i,
  input wire logic io_ack_o,
  input wire logic [31:0] io_rdata_o,
  input wire logic sysctl_wr_i,
  input wire logic [31:0] sysctl_wdata_i,
  input wire logic [31:0] sysctl_o,
  input wire logic mst_req_o,
  input wire logic mst_gnt_i,
  input wire logic bus_idle_i,
  input wire logic mst_start_o,
  input wire logic mst_write_o,
  input wire logic card_oe_n_o,
  input wire logic card_we_n_o,
  input wire logic card_reg_n_o,
  input wire logic serial_channel_request_o,
  input wire logic distributed_dma_busy_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  AST_IO_ACK: assert property (
    io_req_i && ce_i |=> io_ack_o) else $error("io ack missing");
  AST_ACK_CAUSE: assert property (
    io_ack_o |-> $past(io_req_i && ce_i)) else $error("stray io ack");
  AST_RDATA_IDLE: assert property (
    !io_ack_o |-> io_rdata_o == 32'h0) else $error("rdata not zero");
  AST_START_GNT: assert property (
    mst_start_o |-> $past(mst_req_o && mst_gnt_i && bus_idle_i))
    else $error("start without grant");
  AST_NO_IDLE: assert property (
    mst_req_o && mst_gnt_i && !bus_idle_i && ce_i |=> !mst_start_o)
    else $error("start on busy bus");
  AST_START_ONE: assert property (
    mst_start_o |=> !mst_start_o) else $error("start too long");
  AST_END_OE: assert property (
    !card_oe_n_o |=> card_oe_n_o) else $error("oe end pulse long");
  AST_END_ONE: assert property (
    card_oe_n_o || card_we_n_o) else $error("both end pins low");
  AST_ACK_BUSY: assert property (
    !card_reg_n_o && !sysctl_o[19] |->
    distributed_dma_busy_o || $past(distributed_dma_busy_o))
    else $error("card ack while idle");
  AST_SER_IDLE: assert property (
    !sysctl_o[19] |-> serial_channel_request_o)
    else $error("serial request while disabled");
  AST_SYS_SET: assert property (
    $rose(sysctl_o[19]) |-> $past(sysctl_wr_i && sysctl_wdata_i[19], 2))
    else $error("socket enable set unprompted");
  cover property (mst_start_o && mst_write_o);
  cover property (mst_start_o && !mst_write_o);
  cover property (!card_we_n_o);
  cover property (!card_oe_n_o);
endmodule
bind pc_card_dma pc_card_dma_monitor mon_u (.clk_i, .srst_i, .ce_i,
  .io_req_i, .io_ack_o, .io_rdata_o, .sysctl_wr_i, .sysctl_wdata_i,
  .sysctl_o, .mst_req_o, .mst_gnt_i, .bus_idle_i, .mst_start_o,
  .mst_write_o, .card_oe_n_o, .card_we_n_o, .card_reg_n_o,
  .serial_channel_request_o, .distributed_dma_busy_o);

// *** verification/pc_card_dma_partner.sv ***
// behavioural pci bus and card model for the dma engine bench
`timescale 1ns/1ns
module pc_card_dma_partner (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // pci side
  input wire logic mst_req_i,
  input wire logic mst_start_i,
  input wire logic mst_write_i,
  input wire logic [31:0] mst_addr_i,
  output logic mst_gnt_o,
  output logic bus_idle_o,
  output logic mst_done_o,
  output logic [31:0] mst_rdata_o,
  // card side
  input wire logic card_src_i,
  input wire logic card_reg_n_i,
  input wire logic card_wr_stb_i,
  output logic card_rvalid_o,
  output logic [15:0] card_rdata_o,
  output logic card_wr_done_o
);
  logic [7:0] tick;
  logic [7:0] elem;
  logic [1:0] dly;
  logic armed;
  initial begin
    {mst_gnt_o, bus_idle_o, mst_done_o, card_rvalid_o} = 4'h0;
    card_wr_done_o = 1'b0;
    mst_rdata_o = 32'h0;
    card_rdata_o = 16'h0;
    tick = 8'h00;
  end
  always @(negedge clk_i) begin
    tick <= tick + 8'h01;
    // grant comes late and the bus is busy now and then
    mst_gnt_o <= mst_req_i && tick[1];
    bus_idle_o <= tick[2:0] != 3'h5;
    mst_done_o <= 1'b0;
    card_rvalid_o <= 1'b0;
    card_wr_done_o <= card_wr_stb_i;
    // released data lines keep toggling
    mst_rdata_o <= ~mst_rdata_o;
    card_rdata_o <= ~card_rdata_o;
    if (srst_i) begin
      armed <= 1'b1;
      elem <= 8'h00;
      dly <= 2'd0;
    end else begin
      if (card_src_i && armed && !card_reg_n_i) begin
        card_rvalid_o <= 1'b1;
        card_rdata_o <= {8'h5a, elem};
        armed <= 1'b0;
      end
      if (mst_start_i) dly <= 2'd3;
      else if (dly != 2'd0) dly <= dly - 2'd1;
      if (dly == 2'd1) begin
        mst_done_o <= 1'b1;
        armed <= 1'b1;
        elem <= elem + 8'h01;
        if (!mst_write_i) mst_rdata_o <= {16'hbeef, mst_addr_i[15:0]};
      end
    end
  end
endmodule

// *** verification/test_pc_card_dma.sv ***
// self-checking bench for the pc card 16 dma engine
`timescale 1ns/1ns
module test_pc_card_dma;
  import pc_card_dma_pkg::*;
  localparam logic [15:0] B = 16'h0a50;
  logic clk_i, srst_i, ce_i, io_req_i, io_wr_i, io_ack_o;
  logic [15:0] io_addr_i;
  logic [3:0] io_be_i;
  logic [31:0] io_wdata_i, io_rdata_o, sysctl_wdata_i, sysctl_o;
  logic distributed_dma_enable_i, distributed_dma_word_i, sysctl_wr_i;
  card_dma_request_sel_t card_dma_request_select_i;
  logic [11:0] distributed_dma_base_i;
  logic [31:0] mst_addr_o, mst_wdata_o, mst_rdata_i;
  logic mst_req_o, mst_gnt_i, bus_idle_i, mst_start_o, mst_write_o;
  logic mst_word_o, mst_done_i, card_rvalid_i, card_wr_stb_o;
  logic card_audio_pin_n_i, card_io16_pin_n_i, card_input_ack_pin_n_i;
  logic [15:0] card_rdata_i, card_wdata_o;
  logic card_wr_done_i, card_oe_n_o, card_we_n_o, card_reg_n_o;
  logic serial_channel_request_o, serial_channel_grant_i;
  logic distributed_dma_busy_o, card_src;
  logic [31:0] rs;
  logic [40:0] e;
  logic [32:0] qio[$];
  logic [40:0] qm[$];
  logic [15:0] qc[$];
  int fails, checked, cyc, n_oe, n_we;
  pc_card_dma dut_u (.clk_i, .srst_i, .ce_i, .io_req_i, .io_wr_i,
    .io_addr_i, .io_be_i, .io_wdata_i, .io_ack_o, .io_rdata_o,
    .distributed_dma_enable_i, .card_dma_request_select_i, .distributed_dma_base_i,
    .distributed_dma_word_i, .sysctl_wr_i, .sysctl_wdata_i, .sysctl_o,
    .mst_req_o, .mst_gnt_i, .bus_idle_i, .mst_start_o, .mst_write_o,
    .mst_word_o, .mst_addr_o, .mst_wdata_o, .mst_done_i, .mst_rdata_i,
    .card_audio_pin_n_i, .card_io16_pin_n_i, .card_input_ack_pin_n_i,
    .card_rdata_i, .card_rvalid_i, .card_wdata_o, .card_wr_stb_o,
    .card_wr_done_i, .card_oe_n_o, .card_we_n_o, .card_reg_n_o,
    .serial_channel_request_o, .serial_channel_grant_i,
    .distributed_dma_busy_o);
  pc_card_dma_partner far_u (.clk_i(clk_i), .srst_i(srst_i),
    .mst_req_i(mst_req_o), .mst_start_i(mst_start_o),
    .mst_write_i(mst_write_o), .mst_addr_i(mst_addr_o),
    .mst_gnt_o(mst_gnt_i), .bus_idle_o(bus_idle_i),
    .mst_done_o(mst_done_i), .mst_rdata_o(mst_rdata_i),
    .card_src_i(card_src), .card_reg_n_i(card_reg_n_o),
    .card_wr_stb_i(card_wr_stb_o), .card_rvalid_o(card_rvalid_i),
    .card_rdata_o(card_rdata_i), .card_wr_done_o(card_wr_done_i));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic io(input logic w, input logic [15:0] a,
      input logic [3:0] be, input logic [31:0] d, input logic [31:0] x);
    @(negedge clk_i);
    io_req_i = 1'b1;
    io_wr_i = w;
    io_addr_i = a;
    io_be_i = be;
    io_wdata_i = d;
    qio.push_back({!w, x});
    @(negedge clk_i);
    io_req_i = 1'b0;
  endtask
  task automatic wt();
    int k = 0;
    while ((qm.size() + qc.size() != 0 || distributed_dma_busy_o !== 1'b0)
        && k < 3000) begin
      @(negedge clk_i);
      k++;
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  // outputs are settled at the falling edge
  always @(negedge clk_i) begin
    if (io_ack_o === 1'b1) begin
      e = {8'h0, qio.pop_front()};
      if (e[32]) chk(io_rdata_o, e[31:0]);
    end
    if (mst_start_o === 1'b1) begin
      if (qm.size() == 0) chk(mst_start_o, 1'b0);
      else begin
        e = qm.pop_front();
        chk(mst_addr_o, e[39:8]);
        chk(mst_write_o, e[40]);
        chk(mst_word_o, distributed_dma_word_i);
        if (e[40]) chk(mst_wdata_o[7:0], e[7:0]);
      end
    end
    if (card_wr_stb_o === 1'b1) chk(card_wdata_o, qc.pop_front());
    n_oe += (card_oe_n_o === 1'b0);
    n_we += (card_we_n_o === 1'b0);
  end
  initial begin
    {srst_i, ce_i, distributed_dma_enable_i, serial_channel_grant_i} = 4'hf;
    {io_req_i, io_wr_i, distributed_dma_word_i, sysctl_wr_i} = 4'h0;
    {card_audio_pin_n_i, card_io16_pin_n_i, card_input_ack_pin_n_i} = 3'h7;
    {io_addr_i, io_be_i, io_wdata_i, sysctl_wdata_i} = '0;
    card_dma_request_select_i = SEL_AUDIO;
    distributed_dma_base_i = B[15:4];
    card_src = 1'b0;
    rs = 32'he9126655;
    repeat (5) @(negedge clk_i);
    srst_i = 1'b0;
    chk(sysctl_o, 32'h0);
    io(0, B + 16'h8, 4'hf, 0, 32'h0);
    io(0, 16'h1230, 4'hf, 0, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      io(1, B + 16'h4, 4'h3, rs, 0);
      io(0, B + 16'h4, 4'hf, 0, {16'h0, rs[15:0]});
    end
    io(1, B, 4'hf, 32'hff12_3400, 0);
    io(0, B, 4'hf, 0, 32'h0012_3400);
    // two bytes card to memory on the audio terminal
    io(1, B + 16'h4, 4'h3, 32'h1, 0);
    io(1, B + 16'h8, 4'h9, 32'h0400_0000, 0);
    qm.push_back({1'b1, 32'h0012_3400, 8'h00});
    qm.push_back({1'b1, 32'h0012_3401, 8'h01});
    io(1, B + 16'hc, 4'h8, 0, 0);
    card_src = 1'b1;
    card_audio_pin_n_i = 1'b0;
    wt();
    card_audio_pin_n_i = 1'b1;
    io(0, B + 16'h8, 4'hf, 0, 32'h1);
    chk(n_oe, 1);
    io(0, B + 16'h8, 4'hf, 0, 32'h0);
    // one word memory to card on the io16 terminal
    distributed_dma_word_i = 1'b1;
    card_dma_request_select_i = SEL_IO16;
    card_src = 1'b0;
    io(1, B, 4'h7, 32'h4a6c, 0);
    io(1, B + 16'h4, 4'h3, 32'h0, 0);
    io(1, B + 16'h8, 4'h9, 32'h0800_0000, 0);
    qm.push_back({1'b0, 32'h0000_4a6c, 8'h00});
    qc.push_back(16'h4a6c);
    io(1, B + 16'hc, 4'h8, 0, 0);
    card_io16_pin_n_i = 1'b0;
    wt();
    card_io16_pin_n_i = 1'b1;
    io(0, B + 16'h8, 4'hf, 0, 32'h1);
    chk(n_we, 1);
    // channel reset during the first byte's bus write, input-ack terminal
    distributed_dma_word_i = 1'b0;
    card_dma_request_select_i = SEL_CARD_INPUT_ACK_PIN;
    card_src = 1'b1;
    io(1, B, 4'h7, 32'h100, 0);
    io(1, B + 16'h4, 4'h3, 32'h5, 0);
    io(1, B + 16'h8, 4'h9, 32'h0400_0000, 0);
    qm.push_back({1'b1, 32'h0000_0100, 8'h03});
    io(1, B + 16'hc, 4'h8, 0, 0);
    card_input_ack_pin_n_i = 1'b0;
    while (qm.size() != 0) @(negedge clk_i);
    io(1, B + 16'hc, 4'h2, 0, 0);
    wt();
    chk(card_reg_n_o, 1'b1);
    card_input_ack_pin_n_i = 1'b1;
    io(0, B + 16'h8, 4'hf, 0, 32'h1);
    chk(n_oe, 2);
    // system control: only the enables and channel field stick
    @(negedge clk_i);
    sysctl_wr_i = 1'b1;
    sysctl_wdata_i = 32'hffff_ffff;
    @(negedge clk_i);
    sysctl_wr_i = 1'b0;
    @(negedge clk_i);
    chk(sysctl_o, 32'h000f_0008);
    // centralized: channel 7 granted, normal tc write reaches the card
    card_input_ack_pin_n_i = 1'b0;
    repeat (8) @(negedge clk_i);
    for (int i = 0; i < 4; i++) begin
      serial_channel_grant_i = (i != 0);
      @(negedge clk_i);
    end
    qc.push_back(16'hc35a);
    io(1, 16'h0004, 4'h3, 32'h0001_c35a, 0);
    io(1, 16'h00c4, 4'h3, 32'h1, 0);
    io(0, B + 16'h8, 4'hf, 0, 32'h10);
    chk(n_we, 2);
    chk(card_reg_n_o, 1'b0);
    tally_and_finish();
  end
endmodule
